/* common/pwmioc_consts.svh */
`ifndef PWMIOC_CONSTS_SVH
`define PWMIOC_CONSTS_SVH

// register byte offsets
`define PWMIOC_OFF_OUTCTL 8'h00
`define PWMIOC_OFF_KEY 8'h04
`define PWMIOC_OFF_UNITCTL 8'h08
`define PWMIOC_OFF_STATUS 8'h0c

// output control field positions
`define PWMIOC_CURRENT_LIMIT_SOURCE_SELECT_MSB 29
`define PWMIOC_CURRENT_LIMIT_SOURCE_SELECT_LSB 26
`define PWMIOC_FAULT_SOURCE_SELECT_MSB 24
`define PWMIOC_FAULT_SOURCE_SELECT_LSB 21
`define PWMIOC_FAULT_MODE_SELECT_BIT 16
`define PWMIOC_HIGH_SIDE_PIN_OWNERSHIP_BIT 15
`define PWMIOC_LOW_SIDE_PIN_OWNERSHIP_BIT 14
`define PWMIOC_HIGH_SIDE_POLARITY_BIT 13
`define PWMIOC_POLL_BIT 12
`define PWMIOC_CURRENT_LIMIT_MODE_ENABLE_BIT 8
`define PWMIOC_CLDATH_BIT 5
`define PWMIOC_CLDATL_BIT 4
`define PWMIOC_FLTDATH_BIT 3
`define PWMIOC_FLTDATL_BIT 2

// writable bits of output control, everything else reads zero
`define PWMIOC_OUTCTL_MASK 32'h3de1_f13c
`define PWMIOC_OUTCTL_RESET 32'h0000_0000

// unit control and status bits
`define PWMIOC_UNIT_EN_BIT 0
`define PWMIOC_ST_UNLOCKED_BIT 0
`define PWMIOC_ST_CL_BIT 1
`define PWMIOC_ST_FLT_BIT 2
`define PWMIOC_ST_REJECT_BIT 3

// unlock key pair
`define PWMIOC_KEY_FIRST 16'habcd
`define PWMIOC_KEY_SECOND 16'h4321

`endif

/* common/pwmioc_pkg.sv */
package pwmioc_pkg;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pwmioc_apb_req_type;

    // one output pin: level and drive enable
    typedef struct packed {
        logic o;
        logic oe;
    } pwmioc_pin_type;

    // port logic request for one pin
    typedef struct packed {
        logic o;
        logic oe;
    } pwmioc_gpio_type;

    // key sequence tracking
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_FIRST_SEEN,
        KEY_OPEN
    } pwmioc_key_state_type;

endpackage

/* design/pwmioc_srcsel.sv */
`timescale 1ns/1ns
// picks one of fault pins 1..8, comparators 1..5 or fault pin 15
module pwmioc_srcsel
(
    input wire logic [14:0] fault_pins,
    input wire logic [4:0] comparators,
    input wire logic [3:0] sel,
    output logic selected
);
    // fault pins 9..14 have no code; reserved codes read inactive
    always_comb
    begin
        selected = 1'b0;
        if (sel[3] == 1'b0)
        begin
            selected = fault_pins[sel[2:0]];
        end
        else if (sel == 4'hf)
        begin
            selected = fault_pins[14];
        end
        else if (sel[2:0] <= 3'h4)
        begin
            selected = comparators[sel[2:0]];
        end
        else
        begin
            selected = 1'b0;
        end
    end
endmodule

/* design/pwmioc_pinmux.sv */
`timescale 1ns/1ns
// one pin: ownership, override and polarity translation
module pwmioc_pinmux
(
    input wire logic own,
    input wire logic pol,
    input wire logic pwm_active,
    input wire logic flt_hit,
    input wire logic flt_data,
    input wire logic cl_hit,
    input wire logic cl_data,
    input wire pwmioc_pkg::pwmioc_gpio_type gpio,
    output pwmioc_pkg::pwmioc_pin_type pin
);
    import pwmioc_pkg::*;

    logic state;

    // fault outranks current limit; data bits mean active/inactive
    always_comb
    begin
        if (flt_hit)
        begin
            state = flt_data;
        end
        else if (cl_hit)
        begin
            state = cl_data;
        end
        else
        begin
            state = pwm_active;
        end
    end

    // polarity 1 means active low
    always_comb
    begin
        if (own)
        begin
            pin.o = state ^ pol;
            pin.oe = 1'b1;
        end
        else
        begin
            pin.o = gpio.o;
            pin.oe = gpio.oe;
        end
    end
endmodule

/* design/pwmioc_top.sv */
// Function
// - current-limit source codes 0..7 pick fault pins 1..8, 8..12 pick comparators 1..5, 15 picks fault pin 15, 13 and 14 are reserved.
// - with the lock fuse at 0 output control writes need the key sequence, with the fuse at 1 they always land.
// - only the ordered key pair abcd then 4321 in two consecutive key writes unlocks.
// - the output control write must be the very next register access after the key pair or it is refused.
// - with the ownership bits at 0 the pins stay with the port logic; during reset the pin registers load zero and both pins are undriven.
// - override data means active or inactive state and is translated through the polarity bits.
// - current-limit and fault sources are chosen independently among the same 14 inputs.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`include "pwmioc_consts.svh"
module pwmioc_top
(
    input wire logic clock,
    input wire logic rst,
    input wire pwmioc_pkg::pwmioc_apb_req_type apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic output_control_lock_fuse,
    input wire logic [14:0] external_fault_pin,
    input wire logic [4:0] comparator_in,
    input wire logic pwm_high_active,
    input wire logic pwm_low_active,
    input wire pwmioc_pkg::pwmioc_gpio_type gpio_high,
    input wire pwmioc_pkg::pwmioc_gpio_type gpio_low,
    output pwmioc_pkg::pwmioc_pin_type high_side_output_pin,
    output pwmioc_pkg::pwmioc_pin_type low_side_output_pin,
    output logic unit_global_enable,
    output logic current_limit_active,
    output logic fault_active
);
    import pwmioc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic pready_reg;
    logic pready_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [31:0] pwm_output_control_x_reg;
    logic unit_enable_reg;
    logic reject_reg;
    logic cl_reg;
    logic flt_reg;
    pwmioc_key_state_type key_state_reg;
    pwmioc_key_state_type key_state_next;
    pwmioc_pin_type high_pin_reg;
    pwmioc_pin_type low_pin_reg;
    pwmioc_pin_type high_pin_next;
    pwmioc_pin_type low_pin_next;
    logic access_done;
    logic wr_done;
    logic hit_outctl;
    logic hit_key;
    logic hit_unitctl;
    logic hit_status;
    logic addr_known;
    logic outctl_allowed;
    logic outctl_write;
    logic outctl_refused;
    logic [3:0] current_limit_source_select;
    logic [3:0] fault_source_select;
    logic current_limit_mode_enable;
    logic fault_mode_select;
    logic high_side_pin_ownership;
    logic low_side_pin_ownership;
    logic high_side_polarity;
    logic low_side_polarity;
    logic cl_selected;
    logic flt_selected;
    logic cl_hit;
    logic flt_hit;
    logic [15:0] key_word;

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    // a transfer completes in the cycle pready is seen high
    assign access_done = apb_req.psel & apb_req.penable & pready_reg;
    assign wr_done = access_done & apb_req.pwrite;
    assign hit_outctl = apb_req.paddr == `PWMIOC_OFF_OUTCTL;
    assign hit_key = apb_req.paddr == `PWMIOC_OFF_KEY;
    assign hit_unitctl = apb_req.paddr == `PWMIOC_OFF_UNITCTL;
    assign hit_status = apb_req.paddr == `PWMIOC_OFF_STATUS;
    assign addr_known = hit_outctl | hit_key | hit_unitctl | hit_status;
    assign key_word = apb_req.pwdata[15:0];

    // fuse at 1 opens the register; fuse at 0 needs a fresh key pair
    assign outctl_allowed = output_control_lock_fuse |
        (key_state_reg == KEY_OPEN);
    assign outctl_write = wr_done & hit_outctl & outctl_allowed;
    assign outctl_refused = wr_done & hit_outctl & ~outctl_allowed;

    ////////////////////////////////////////////////////////////////////////
    // field views of the output control register

    assign current_limit_source_select =
        pwm_output_control_x_reg[`PWMIOC_CURRENT_LIMIT_SOURCE_SELECT_MSB:`PWMIOC_CURRENT_LIMIT_SOURCE_SELECT_LSB];
    assign fault_source_select =
        pwm_output_control_x_reg[`PWMIOC_FAULT_SOURCE_SELECT_MSB:`PWMIOC_FAULT_SOURCE_SELECT_LSB];
    assign current_limit_mode_enable =
        pwm_output_control_x_reg[`PWMIOC_CURRENT_LIMIT_MODE_ENABLE_BIT];
    assign fault_mode_select = pwm_output_control_x_reg[`PWMIOC_FAULT_MODE_SELECT_BIT];
    assign high_side_pin_ownership =
        pwm_output_control_x_reg[`PWMIOC_HIGH_SIDE_PIN_OWNERSHIP_BIT];
    assign low_side_pin_ownership =
        pwm_output_control_x_reg[`PWMIOC_LOW_SIDE_PIN_OWNERSHIP_BIT];
    assign high_side_polarity = pwm_output_control_x_reg[`PWMIOC_HIGH_SIDE_POLARITY_BIT];
    assign low_side_polarity = pwm_output_control_x_reg[`PWMIOC_POLL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // apb handshake: one wait state, answer from registers

    // pready rises in the second access cycle, never twice in a row
    always_comb
    begin
        pready_next = apb_req.psel & apb_req.penable & ~pready_reg;
    end

    // read data and error prepared together with pready
    always_comb
    begin
        prdata_next = 32'h0000_0000;
        pslverr_next = 1'b0;
        if (pready_next)
        begin
            pslverr_next = ~addr_known;
            if (~apb_req.pwrite)
            begin
                if (hit_outctl)
                begin
                    prdata_next = pwm_output_control_x_reg;
                end
                else if (hit_unitctl)
                begin
                    prdata_next[`PWMIOC_UNIT_EN_BIT] = unit_enable_reg;
                end
                else if (hit_status)
                begin
                    prdata_next[`PWMIOC_ST_UNLOCKED_BIT] =
                        key_state_reg == KEY_OPEN;
                    prdata_next[`PWMIOC_ST_CL_BIT] = cl_reg;
                    prdata_next[`PWMIOC_ST_FLT_BIT] = flt_reg;
                    prdata_next[`PWMIOC_ST_REJECT_BIT] = reject_reg;
                end
                else
                begin
                    prdata_next = 32'h0000_0000; // key reads zero
                end
            end
        end
    end

    // handshake flops
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= pready_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // key sequence

    // only completed accesses move the tracker; any stray access relocks
    always_comb
    begin
        key_state_next = key_state_reg;
        if (access_done)
        begin
            case (key_state_reg)
                KEY_IDLE:
                begin
                    if (wr_done & hit_key & key_word == `PWMIOC_KEY_FIRST)
                    begin
                        key_state_next = KEY_FIRST_SEEN;
                    end
                end
                KEY_FIRST_SEEN:
                begin
                    if (wr_done & hit_key & key_word == `PWMIOC_KEY_SECOND)
                    begin
                        key_state_next = KEY_OPEN;
                    end
                    else if (wr_done & hit_key &
                        key_word == `PWMIOC_KEY_FIRST)
                    begin
                        key_state_next = KEY_FIRST_SEEN;
                    end
                    else
                    begin
                        key_state_next = KEY_IDLE;
                    end
                end
                KEY_OPEN:
                begin
                    // the window lasts exactly one access of any kind
                    if (wr_done & hit_key & key_word == `PWMIOC_KEY_FIRST)
                    begin
                        key_state_next = KEY_FIRST_SEEN;
                    end
                    else
                    begin
                        key_state_next = KEY_IDLE;
                    end
                end
                default:
                begin
                    key_state_next = KEY_IDLE;
                end
            endcase
        end
    end

    // key tracker flop
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            key_state_reg <= KEY_IDLE;
        end
        else
        begin
            key_state_reg <= key_state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers

    // protected output control; refused writes leave it untouched
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pwm_output_control_x_reg <= `PWMIOC_OUTCTL_RESET;
        end
        else if (outctl_write)
        begin
            pwm_output_control_x_reg <=
                apb_req.pwdata & `PWMIOC_OUTCTL_MASK;
        end
    end

    // unit enable; pin ownership and source choice are set beforehand
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            unit_enable_reg <= 1'b0;
        end
        else if (wr_done & hit_unitctl)
        begin
            unit_enable_reg <= apb_req.pwdata[`PWMIOC_UNIT_EN_BIT];
        end
    end

    // sticky refusal flag, write 1 clears, a new refusal wins
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            reject_reg <= 1'b0;
        end
        else if (outctl_refused)
        begin
            reject_reg <= 1'b1;
        end
        else if (wr_done & hit_status &
            apb_req.pwdata[`PWMIOC_ST_REJECT_BIT])
        begin
            reject_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source selection and pin drive

    // two independent pickers over the same inputs
    pwmioc_srcsel u_cl_sel
    (
        .fault_pins(external_fault_pin),
        .comparators(comparator_in),
        .sel(current_limit_source_select),
        .selected(cl_selected)
    );

    pwmioc_srcsel u_flt_sel
    (
        .fault_pins(external_fault_pin),
        .comparators(comparator_in),
        .sel(fault_source_select),
        .selected(flt_selected)
    );

    // overrides only act while the unit runs
    assign cl_hit = unit_enable_reg & current_limit_mode_enable & cl_selected;
    assign flt_hit = unit_enable_reg & fault_mode_select & flt_selected;

    pwmioc_pinmux u_high
    (
        .own(high_side_pin_ownership),
        .pol(high_side_polarity),
        .pwm_active(pwm_high_active & unit_enable_reg),
        .flt_hit(flt_hit),
        .flt_data(pwm_output_control_x_reg[`PWMIOC_FLTDATH_BIT]),
        .cl_hit(cl_hit),
        .cl_data(pwm_output_control_x_reg[`PWMIOC_CLDATH_BIT]),
        .gpio(gpio_high),
        .pin(high_pin_next)
    );

    pwmioc_pinmux u_low
    (
        .own(low_side_pin_ownership),
        .pol(low_side_polarity),
        .pwm_active(pwm_low_active & unit_enable_reg),
        .flt_hit(flt_hit),
        .flt_data(pwm_output_control_x_reg[`PWMIOC_FLTDATL_BIT]),
        .cl_hit(cl_hit),
        .cl_data(pwm_output_control_x_reg[`PWMIOC_CLDATL_BIT]),
        .gpio(gpio_low),
        .pin(low_pin_next)
    );

    // pins and status registered; costs one cycle of override latency
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            high_pin_reg <= '0;
            low_pin_reg <= '0;
            cl_reg <= 1'b0;
            flt_reg <= 1'b0;
        end
        else
        begin
            high_pin_reg <= high_pin_next;
            low_pin_reg <= low_pin_next;
            cl_reg <= cl_hit;
            flt_reg <= flt_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign high_side_output_pin = high_pin_reg;
    assign low_side_output_pin = low_pin_reg;
    assign unit_global_enable = unit_enable_reg;
    assign current_limit_active = cl_reg;
    assign fault_active = flt_reg;
endmodule

/* bench/pwmioc_props.sv */
`timescale 1ns/1ns
`include "pwmioc_consts.svh"
// bus answer and override checks seen from the block's ports
module pwmioc_props
(
    input wire logic clock,
    input wire logic rst,
    input wire pwmioc_pkg::pwmioc_apb_req_type apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic unit_global_enable,
    input wire logic current_limit_active,
    input wire logic fault_active
);
    import pwmioc_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // one wait state, then a single answer cycle
    wait_state_a: assert property (
        apb_req.psel && $rose(apb_req.penable) |-> !pready ##1 pready)
        else $error("answer not in second access cycle");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside answer");
    unmapped_err_a: assert property (
        pready && (apb_req.paddr > `PWMIOC_OFF_STATUS ||
        apb_req.paddr[1:0] != 2'b00) |-> pslverr)
        else $error("unmapped access without error");
    mapped_ok_a: assert property (
        pready && apb_req.paddr <= `PWMIOC_OFF_STATUS &&
        apb_req.paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access answered with error");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    ////////////////////////////////////////////////////////////////////////
    // enable moves only on a completed write to its register
    enable_write_a: assert property (
        pready && apb_req.pwrite && apb_req.paddr == `PWMIOC_OFF_UNITCTL
        |=> unit_global_enable == $past(apb_req.pwdata[0]))
        else $error("enable not taken from write data");
    enable_hold_a: assert property (
        !(pready && apb_req.pwrite && apb_req.paddr == `PWMIOC_OFF_UNITCTL)
        |=> $stable(unit_global_enable))
        else $error("enable changed without a write");
    // overrides are gated by the unit enable
    override_gate_a: assert property (
        !unit_global_enable |=> !fault_active && !current_limit_active)
        else $error("override active while unit disabled");
endmodule

/* bench/pwmioc_stage.sv */
`timescale 1ns/1ns
// far side: fault and comparator sources plus the two pads
module pwmioc_stage
(
    input wire logic clock,
    input wire logic [19:0] drive_req,
    input wire pwmioc_pkg::pwmioc_pin_type high_pin,
    input wire pwmioc_pkg::pwmioc_pin_type low_pin,
    output logic [14:0] fault_out,
    output logic [4:0] comp_out,
    output logic high_pad,
    output logic low_pad
);
    import pwmioc_pkg::*;
    // sources switch just after an edge, each on its own line
    initial {comp_out, fault_out} = 20'h0;
    always @(posedge clock)
    begin
        {comp_out, fault_out} <= drive_req;
    end
    // an undriven pad falls to the board pull-down
    assign high_pad = high_pin.oe ? high_pin.o : 1'b0;
    assign low_pad = low_pin.oe ? low_pin.o : 1'b0;
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ns
`include "pwmioc_consts.svh"
module testbench;
    import pwmioc_pkg::*;
    localparam logic [7:0] OC = `PWMIOC_OFF_OUTCTL;
    localparam logic [7:0] KY = `PWMIOC_OFF_KEY;
    localparam logic [7:0] UC = `PWMIOC_OFF_UNITCTL;
    localparam logic [7:0] ST = `PWMIOC_OFF_STATUS;
    localparam logic [31:0] K1 = {16'h0, `PWMIOC_KEY_FIRST};
    localparam logic [31:0] K2 = {16'h0, `PWMIOC_KEY_SECOND};
    localparam logic [31:0] OWNH = 32'h1 << `PWMIOC_HIGH_SIDE_PIN_OWNERSHIP_BIT;
    localparam logic [31:0] CLM = (32'h1 << `PWMIOC_CURRENT_LIMIT_MODE_ENABLE_BIT)
        | (32'h1 << `PWMIOC_CLDATH_BIT);
    localparam logic [31:0] FLM = (32'h1 << `PWMIOC_FAULT_MODE_SELECT_BIT)
        | (32'h1 << `PWMIOC_FLTDATH_BIT) | (32'h1 << `PWMIOC_HIGH_SIDE_POLARITY_BIT);
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic fuse = 1'b0;
    logic hi_act = 1'b0;
    logic lo_act = 1'b0;
    pwmioc_apb_req_type req = '0;
    pwmioc_gpio_type gp_h = 2'b11;
    pwmioc_gpio_type gp_l = 2'b01;
    pwmioc_pin_type pin_h;
    pwmioc_pin_type pin_l;
    logic [19:0] drive_req = 20'h0;
    logic [19:0] src;
    logic [14:0] flt;
    logic [4:0] cmp;
    logic [31:0] prdata;
    logic [31:0] q;
    logic pready, pslverr, e, en, cl_act, flt_act, pad_h, pad_l, hit;
    int error_cnt = 0;
    int cmp_count = 0;
    // free-running 125 MHz clock
    always #4 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    pwmioc_top DUT
    (
        .clock(clock),
        .rst(rst),
        .apb_req(req),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .output_control_lock_fuse(fuse),
        .external_fault_pin(flt),
        .comparator_in(cmp),
        .pwm_high_active(hi_act),
        .pwm_low_active(lo_act),
        .gpio_high(gp_h),
        .gpio_low(gp_l),
        .high_side_output_pin(pin_h),
        .low_side_output_pin(pin_l),
        .unit_global_enable(en),
        .current_limit_active(cl_act),
        .fault_active(flt_act)
    );
    pwmioc_stage stage
    (
        .clock(clock),
        .drive_req(drive_req),
        .high_pin(pin_h),
        .low_pin(pin_l),
        .fault_out(flt),
        .comp_out(cmp),
        .high_pad(pad_h),
        .low_pad(pad_l)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    // one apb transfer, held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clock);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            error_cnt++;
            $display("ERROR t=%0t no bus answer", $time);
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(q, x);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence; all stimulus lands on clock edges
    initial
    begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        idle(3);
        check(pin_h, 2'b11);
        check(pin_l, 2'b01);
        rd(ST, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check(e, 1'b1);
        check(q, 32'h0);
        apb(1'b0, 8'h01, 32'h0);
        check(e, 1'b1);
        // locked: a bare write is dropped and flagged
        wr(OC, OWNH);
        rd(OC, 32'h0);
        rd(ST, 32'h8);
        wr(ST, 32'h8);
        rd(ST, 32'h0);
        wr(KY, K2);
        wr(KY, K1);
        wr(OC, OWNH);
        rd(OC, 32'h0);
        wr(KY, K1);
        wr(KY, K2);
        rd(ST, 32'h9);
        rd(UC, 32'h0);
        wr(OC, OWNH);
        rd(OC, 32'h0);
        wr(KY, K1);
        wr(KY, K2);
        wr(OC, OWNH);
        rd(OC, OWNH);
        wr(OC, 32'h0);
        rd(OC, OWNH);
        // fuse open: any write lands, unused bits read zero
        fuse <= 1'b1;
        wr(OC, 32'hffff_ffff);
        rd(OC, `PWMIOC_OUTCTL_MASK);
        // every source code, wrong inputs first, then the right one
        for (int c = 0; c < 16; c++)
        begin
            wr(UC, 32'h0);
            wr(OC, OWNH | CLM | (32'(c) << `PWMIOC_CURRENT_LIMIT_SOURCE_SELECT_LSB));
            wr(UC, 32'h1);
            hit = !(c == 13 || c == 14);
            if (c < 8)
                src = 20'h1 << c;
            else if (c < 13)
                src = 20'h1 << (c + 7);
            else if (c == 15)
                src = 20'h1 << 14;
            else
                src = 20'hf_ffff;
            for (int p = 0; p < 2; p++)
            begin
                drive_req <= p ? src : ~src;
                idle(4);
                check(cl_act, p ? hit : 1'b0);
                check(pad_h, p ? hit : 1'b0);
            end
            drive_req <= 20'h0;
        end
        check(pin_l, 2'b01);
        // fault data high with inverted polarity drives the pad low
        wr(UC, 32'h0);
        wr(OC, OWNH | FLM);
        wr(UC, 32'h1);
        idle(4);
        check({flt_act, pad_h}, 2'b01);
        drive_req <= 20'h1;
        idle(4);
        check({flt_act, pad_h}, 2'b10);
        check(en, 1'b1);
        rd(ST, 32'hc);
        complete_run();
    end
endmodule
bind pwmioc_top pwmioc_props u_props
(
    .clock(clock),
    .rst(rst),
    .apb_req(apb_req),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .unit_global_enable(unit_global_enable),
    .current_limit_active(current_limit_active),
    .fault_active(fault_active)
);
